// >>> io_assign_pkg.sv
// Constants and code tables for the terminal function assigner
package io_assign_pkg;

  // Terminal counts and widths
  localparam int CODE_W  = 8;
  localparam int N_DIN   = 10;
  localparam int N_RIN   = 16;
  localparam int N_DOUT  = 6;
  localparam int N_ROUT  = 16;
  localparam int SPEED_W = 16;
  localparam int N_FN    = 16;
  localparam int STEP_W  = 6;

  // Output-only assignment codes
  localparam logic [CODE_W-1:0] CODE_UNUSED        = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ALARM_HIGH    = 8'h81;
  localparam logic [CODE_W-1:0] CODE_ALARM_LOW     = 8'h82;
  localparam logic [CODE_W-1:0] CODE_MOVING        = 8'h86;
  localparam logic [CODE_W-1:0] CODE_WARNING       = 8'h87;
  localparam logic [CODE_W-1:0] CODE_BUSY          = 8'h88;
  localparam logic [CODE_W-1:0] CODE_TORQUE_LIM    = 8'h8c;
  localparam logic [CODE_W-1:0] CODE_SPEED_REACHED = 8'h8d;
  localparam logic [CODE_W-1:0] CODE_ROT_PULSE     = 8'h93;
  localparam logic [CODE_W-1:0] CODE_DIRECTION     = 8'h94;
  localparam logic [CODE_W-1:0] CODE_MAIN_POWER    = 8'ha8;

  // Input function indices into the state vector
  localparam int FN_ALARM_RESET = 0;
  localparam int FN_WARN_CLEAR  = 1;
  localparam int FN_HMI_UNLOCK  = 2;
  localparam int FN_TORQUE_EN   = 3;
  localparam int FN_EXT_FAULT   = 4;
  localparam int FN_RUN_FWD     = 5;
  localparam int FN_RUN_REV     = 6;
  localparam int FN_OP_SEL0     = 7;
  localparam int FN_OP_SEL1     = 8;
  localparam int FN_OP_SEL2     = 9;
  localparam int FN_STOP_DIR    = 10;
  localparam int FN_HOLD_FREE   = 11;
  localparam int FN_GENERAL0    = 12;
  localparam int N_GENERAL      = 4;

  // Input function codes, by index
  localparam logic [CODE_W-1:0] FN_CODES [N_FN] = '{
    8'h08, 8'h0e, 8'h10, 8'h16, 8'h19, 8'h3a, 8'h3b, 8'h40,
    8'h41, 8'h42, 8'h48, 8'h4a, 8'h50, 8'h51, 8'h52, 8'h53
  };

  // Functions that read active when no terminal carries them
  localparam logic [N_FN-1:0] FN_DEFAULT_ON = 16'hf81c;

  // Rotation pulse train: shaft steps per revolution and pulses out
  localparam int STEPS_PER_REV    = 60;
  localparam int PULSES_PER_REV   = 30;
  localparam int STEPS_PER_TOGGLE = STEPS_PER_REV / (2 * PULSES_PER_REV);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEPS_PER_TOGGLE - 1);
  localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;

endpackage

// >>> io_signal_function_assigner.sv
// Maps terminal assignment codes onto input functions and output flags
//
// Operation
// - Codes 65, 66 select second, third data bits
// - Two-wire: code 72 picks stop style
// - Three-wire: code 72 picks rotation direction
// - Code 74 frees held shaft when enabled
// - Codes 80 to 83 are general bits
// - Unassigned hold-release and general bits read high
// - External fault direct only; unassigned reads high
// - Output code 0 leaves terminal unused
// - Output codes 8 to 83 echo inputs
// - Code 129 high while alarm exists
// - Code 130 low while alarm exists
// - Code 134 high while motor runs
// - Code 135 high while warning exists
// - Code 136 high while internally busy
// - Code 140 high while torque limited
// - Code 141 high within speed band
// - Code 147 gives 30 pulses per turn
// - Code 148 high while rotating forward
// - Code 168 high while main power on
// - Pulse train: no remote, fixed polarity
// - Three select bits index eight entries
`timescale 1ns/1ps
module io_signal_function_assigner (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          three_wire_mode,
  input  wire logic                          load_hold_enable,
  input  wire logic                          shaft_held,
  input  wire logic [io_assign_pkg::N_DIN-1:0]  din_level,
  input  wire logic [io_assign_pkg::CODE_W-1:0] din_code [io_assign_pkg::N_DIN],
  input  wire logic [io_assign_pkg::N_RIN-1:0]  rin_level,
  input  wire logic [io_assign_pkg::CODE_W-1:0] rin_code [io_assign_pkg::N_RIN],
  input  wire logic [io_assign_pkg::CODE_W-1:0] dout_code [io_assign_pkg::N_DOUT],
  input  wire logic [io_assign_pkg::N_DOUT-1:0] dout_invert,
  input  wire logic [io_assign_pkg::CODE_W-1:0] rout_code [io_assign_pkg::N_ROUT],
  input  wire logic [io_assign_pkg::N_ROUT-1:0] rout_invert,
  input  wire logic                          alarm_active,
  input  wire logic                          motor_running,
  input  wire logic                          warning_active,
  input  wire logic                          internal_busy,
  input  wire logic                          torque_at_limit,
  input  wire logic [io_assign_pkg::SPEED_W-1:0] feedback_speed,
  input  wire logic [io_assign_pkg::SPEED_W-1:0] command_speed,
  input  wire logic [io_assign_pkg::SPEED_W-1:0] speed_band,
  input  wire logic                          shaft_forward,
  input  wire logic                          shaft_step,
  input  wire logic                          main_power_on,
  output logic [2:0]                         op_data_sel_q,
  output logic                               instant_stop_q,
  output logic                               direction_sel_q,
  output logic                               shaft_free_q,
  output logic [io_assign_pkg::N_GENERAL-1:0] general_bits_q,
  output logic                               external_fault_in_q,
  output logic                               alarm_reset_echo_q,
  output logic                               warning_clear_echo_q,
  output logic [io_assign_pkg::N_DOUT-1:0]   dout_q,
  output logic [io_assign_pkg::N_ROUT-1:0]   rout_q
);
  import io_assign_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input function resolution

  logic [N_FN-1:0]      fn_d;
  logic [N_FN-1:0]      fn_q;
  logic [N_FN-1:0]      fn_assigned_d;
  logic [N_FN-1:0]      fn_assigned_q;
  logic [2:0]           op_data_sel_d;
  logic                 instant_stop_d;
  logic                 direction_sel_d;
  logic                 shaft_free_d;
  logic [N_GENERAL-1:0] general_bits_d;
  logic                 external_fault_in_d;
  logic                 alarm_reset_echo_d;
  logic                 warning_clear_echo_d;

  // Collect every terminal carrying each function, remote ones excepted for external fault, default when none
  always_comb begin
    fn_d          = '0;
    fn_assigned_d = '0;
    for (int f = 0; f < N_FN; f++) begin
      for (int i = 0; i < N_DIN; i++) begin
        if (din_code[i] == FN_CODES[f]) begin
          fn_assigned_d[f] = 1'b1;
          fn_d[f]          = fn_d[f] | din_level[i];
        end
      end
      // External fault ignores remote terminals
      if (f != FN_EXT_FAULT) begin
        for (int i = 0; i < N_RIN; i++) begin
          if (rin_code[i] == FN_CODES[f]) begin
            fn_assigned_d[f] = 1'b1;
            fn_d[f]          = fn_d[f] | rin_level[i];
          end
        end
      end
      if (!fn_assigned_d[f]) begin
        fn_d[f] = FN_DEFAULT_ON[f];
      end
    end
  end

  // Decode resolved functions into their motor-side meanings
  always_comb begin
    op_data_sel_d        = {fn_d[FN_OP_SEL2], fn_d[FN_OP_SEL1], fn_d[FN_OP_SEL0]};
    instant_stop_d       = !three_wire_mode && fn_d[FN_STOP_DIR];
    direction_sel_d      = three_wire_mode && fn_d[FN_STOP_DIR];
    shaft_free_d         = load_hold_enable && shaft_held && fn_d[FN_HOLD_FREE];
    general_bits_d       = fn_d[FN_GENERAL0 +: N_GENERAL];
    external_fault_in_d  = fn_d[FN_EXT_FAULT];
    alarm_reset_echo_d   = fn_d[FN_ALARM_RESET];
    warning_clear_echo_d = fn_d[FN_WARN_CLEAR];
  end

  // Register resolved and decoded input functions
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fn_q                 <= FN_DEFAULT_ON;
      fn_assigned_q        <= '0;
      op_data_sel_q        <= 3'h0;
      instant_stop_q       <= 1'b0;
      direction_sel_q      <= 1'b0;
      shaft_free_q         <= 1'b0;
      general_bits_q       <= '1;
      external_fault_in_q  <= 1'b1;
      alarm_reset_echo_q   <= 1'b0;
      warning_clear_echo_q <= 1'b0;
    end else begin
      fn_q                 <= fn_d;
      fn_assigned_q        <= fn_assigned_d;
      op_data_sel_q        <= op_data_sel_d;
      instant_stop_q       <= instant_stop_d;
      direction_sel_q      <= direction_sel_d;
      shaft_free_q         <= shaft_free_d;
      general_bits_q       <= general_bits_d;
      external_fault_in_q  <= external_fault_in_d;
      alarm_reset_echo_q   <= alarm_reset_echo_d;
      warning_clear_echo_q <= warning_clear_echo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags and rotation pulse train

  logic [SPEED_W-1:0] speed_diff;
  logic               speed_reached_d;
  logic               speed_reached_q;
  logic [STEP_W-1:0]  step_cnt_d;
  logic [STEP_W-1:0]  step_cnt_q;
  logic               rot_pulse_d;
  logic               rot_pulse_q;

  // Speed band check and pulse divider
  always_comb begin
    speed_diff = (feedback_speed >= command_speed) ? feedback_speed - command_speed
                                                   : command_speed - feedback_speed;
    speed_reached_d = (speed_diff <= speed_band);
    step_cnt_d      = step_cnt_q;
    rot_pulse_d     = rot_pulse_q;
    if (shaft_step) begin
      if (step_cnt_q == STEP_LAST) begin
        step_cnt_d  = STEP_ZERO;
        rot_pulse_d = !rot_pulse_q;
      end else begin
        step_cnt_d = step_cnt_q + 6'h01;
      end
    end
  end

  // Register flags and divider
  always_ff @(posedge clock) begin
    if (!resetn) begin
      speed_reached_q <= 1'b0;
      step_cnt_q      <= STEP_ZERO;
      rot_pulse_q     <= 1'b0;
    end else begin
      speed_reached_q <= speed_reached_d;
      step_cnt_q      <= step_cnt_d;
      rot_pulse_q     <= rot_pulse_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output terminal mapping

  // Level for one output terminal, before polarity
  function automatic logic out_level(input logic [CODE_W-1:0] code, input logic remote);
    logic lvl;
    lvl = 1'b0;
    for (int f = 0; f < N_FN; f++) begin
      if (code == FN_CODES[f]) begin
        lvl = fn_q[f];
      end
    end
    case (code)
      CODE_ALARM_HIGH:    lvl = alarm_active;
      CODE_ALARM_LOW:     lvl = !alarm_active;
      CODE_MOVING:        lvl = motor_running;
      CODE_WARNING:       lvl = warning_active;
      CODE_BUSY:          lvl = internal_busy;
      CODE_TORQUE_LIM:    lvl = torque_at_limit;
      CODE_SPEED_REACHED: lvl = speed_reached_q;
      CODE_ROT_PULSE:     lvl = remote ? 1'b0 : rot_pulse_q;
      CODE_DIRECTION:     lvl = shaft_forward;
      CODE_MAIN_POWER:    lvl = main_power_on;
      default:            lvl = lvl;
    endcase
    return lvl;
  endfunction

  // True when polarity inversion may apply to a terminal
  function automatic logic may_invert(input logic [CODE_W-1:0] code, input logic remote);
    logic known;
    known = (code == CODE_ALARM_HIGH) || (code == CODE_ALARM_LOW) ||
            (code == CODE_MOVING) || (code == CODE_WARNING) || (code == CODE_BUSY) ||
            (code == CODE_TORQUE_LIM) || (code == CODE_SPEED_REACHED) ||
            (code == CODE_DIRECTION) || (code == CODE_MAIN_POWER);
    for (int f = 0; f < N_FN; f++) begin
      if (code == FN_CODES[f]) begin
        known = 1'b1;
      end
    end
    // Pulse train and unused terminals keep fixed polarity
    return known && !(remote && code == CODE_ROT_PULSE);
  endfunction

  logic [N_DOUT-1:0] dout_d;
  logic [N_ROUT-1:0] rout_d;

  // Compute next output levels for all terminals
  always_comb begin
    for (int i = 0; i < N_DOUT; i++) begin
      dout_d[i] = out_level(dout_code[i], 1'b0) ^
                  (dout_invert[i] && may_invert(dout_code[i], 1'b0));
    end
    for (int i = 0; i < N_ROUT; i++) begin
      rout_d[i] = out_level(rout_code[i], 1'b1) ^
                  (rout_invert[i] && may_invert(rout_code[i], 1'b1));
    end
  end

  // Register output terminals
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dout_q <= '0;
      rout_q <= '0;
    end else begin
      dout_q <= dout_d;
      rout_q <= rout_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_dout0_code(logic [CODE_W-1:0] c);
    dout_code[0] == c && !dout_invert[0];
  endsequence

  sequence s_rout0_code(logic [CODE_W-1:0] c);
    rout_code[0] == c && !rout_invert[0];
  endsequence

  a_op_sel_index: assert property (@(posedge clock) disable iff (!resetn)
    op_data_sel_q == {fn_q[FN_OP_SEL2], fn_q[FN_OP_SEL1], fn_q[FN_OP_SEL0]})
    else $error("data select index does not follow select bits");

  a_stop_style: assert property (@(posedge clock) disable iff (!resetn)
    !three_wire_mode |=> (instant_stop_q == fn_q[FN_STOP_DIR]) && !direction_sel_q)
    else $error("stop style wrong in two-wire mode");

  a_dir_select: assert property (@(posedge clock) disable iff (!resetn)
    three_wire_mode |=> (direction_sel_q == fn_q[FN_STOP_DIR]) && !instant_stop_q)
    else $error("direction select wrong in three-wire mode");

  a_hold_release: assert property (@(posedge clock) disable iff (!resetn)
    shaft_free_q |-> $past(load_hold_enable) && $past(shaft_held))
    else $error("shaft freed without load holding");

  a_default_on: assert property (@(posedge clock) disable iff (!resetn)
    ((~fn_assigned_q & FN_DEFAULT_ON & ~fn_q) == '0))
    else $error("unassigned function not read as active");

  a_ext_direct: assert property (@(posedge clock) disable iff (!resetn)
    !fn_assigned_q[FN_EXT_FAULT] |-> fn_q[FN_EXT_FAULT] && external_fault_in_q)
    else $error("external fault not active while unassigned");

  a_unused_low: assert property (@(posedge clock) disable iff (!resetn)
    dout_code[0] == CODE_UNUSED |=> !dout_q[0])
    else $error("unused terminal driven high");

  a_echo_input: assert property (@(posedge clock) disable iff (!resetn)
    s_dout0_code(FN_CODES[FN_HOLD_FREE]) |=> dout_q[0] == $past(fn_q[FN_HOLD_FREE]))
    else $error("echo output does not follow input function");

  a_alarm_high: assert property (@(posedge clock) disable iff (!resetn)
    s_dout0_code(CODE_ALARM_HIGH) |=> dout_q[0] == $past(alarm_active))
    else $error("high alarm flag wrong");

  a_alarm_low: assert property (@(posedge clock) disable iff (!resetn)
    s_rout0_code(CODE_ALARM_LOW) |=> rout_q[0] == !$past(alarm_active))
    else $error("low alarm flag wrong");

  a_speed_band: assert property (@(posedge clock) disable iff (!resetn)
    s_dout0_code(CODE_SPEED_REACHED) ##1 s_dout0_code(CODE_SPEED_REACHED)
      |=> dout_q[0] == $past(speed_reached_d, 2))
    else $error("speed reached flag wrong");

  a_pulse_remote: assert property (@(posedge clock) disable iff (!resetn)
    rout_code[0] == CODE_ROT_PULSE |=> !rout_q[0])
    else $error("pulse train reached a remote output");

  a_general_map: assert property (@(posedge clock) disable iff (!resetn)
    general_bits_q == fn_q[FN_GENERAL0 +: N_GENERAL])
    else $error("general bits do not follow their functions");

  a_pulse_toggle: assert property (@(posedge clock) disable iff (!resetn)
    shaft_step && step_cnt_q == STEP_LAST |=> rot_pulse_q != $past(rot_pulse_q))
    else $error("pulse train missed a toggle");

  a_pulse_hold: assert property (@(posedge clock) disable iff (!resetn)
    !shaft_step |=> $stable(rot_pulse_q))
    else $error("pulse train moved without a shaft step");

  a_pulse_direct: assert property (@(posedge clock) disable iff (!resetn)
    dout_code[2] == CODE_ROT_PULSE |=> dout_q[2] == $past(rot_pulse_q))
    else $error("direct pulse output does not follow the divider");

  a_moving_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_rout0_code(CODE_MOVING) |=> rout_q[0] == $past(motor_running))
    else $error("moving flag wrong");

  a_busy_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_rout0_code(CODE_BUSY) |=> rout_q[0] == $past(internal_busy))
    else $error("busy flag wrong");

  a_dir_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_dout0_code(CODE_DIRECTION) |=> dout_q[0] == $past(shaft_forward))
    else $error("direction flag wrong");

  a_power_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_dout0_code(CODE_MAIN_POWER) |=> dout_q[0] == $past(main_power_on))
    else $error("main power flag wrong");

endmodule

// >>> host_io_model.sv
// Host controller model driving terminal levels and assignment codes
`timescale 1ns/1ps
module host_io_model (
  input  wire logic                          clock,
  output logic [io_assign_pkg::N_DIN-1:0]    din_level,
  output logic [io_assign_pkg::CODE_W-1:0]   din_code [io_assign_pkg::N_DIN],
  output logic [io_assign_pkg::N_RIN-1:0]    rin_level,
  output logic [io_assign_pkg::CODE_W-1:0]   rin_code [io_assign_pkg::N_RIN],
  output logic [io_assign_pkg::CODE_W-1:0]   dout_code [io_assign_pkg::N_DOUT],
  output logic [io_assign_pkg::N_DOUT-1:0]   dout_invert,
  output logic [io_assign_pkg::CODE_W-1:0]   rout_code [io_assign_pkg::N_ROUT],
  output logic [io_assign_pkg::N_ROUT-1:0]   rout_invert
);
  import io_assign_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Every terminal unused and low at power-up
  initial begin
    din_level = '0;
    rin_level = '0;
    dout_invert = '0;
    rout_invert = '0;
    foreach (din_code[i]) din_code[i] = CODE_UNUSED;
    foreach (rin_code[i]) rin_code[i] = CODE_UNUSED;
    foreach (dout_code[i]) dout_code[i] = CODE_UNUSED;
    foreach (rout_code[i]) rout_code[i] = CODE_UNUSED;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Direct input: code and level change just after an edge
  task automatic set_din(input int i, input logic [CODE_W-1:0] c, input logic l);
    @(posedge clock);
    din_code[i] <= c;
    din_level[i] <= l;
  endtask
  // Remote input
  task automatic set_rin(input int i, input logic [CODE_W-1:0] c, input logic l);
    @(posedge clock);
    rin_code[i] <= c;
    rin_level[i] <= l;
  endtask
  // Direct output code and polarity
  task automatic set_dout(input int i, input logic [CODE_W-1:0] c, input logic v);
    @(posedge clock);
    dout_code[i] <= c;
    dout_invert[i] <= v;
  endtask
  // Remote output code and polarity
  task automatic set_rout(input int i, input logic [CODE_W-1:0] c, input logic v);
    @(posedge clock);
    rout_code[i] <= c;
    rout_invert[i] <= v;
  endtask
endmodule

// >>> io_signal_function_assigner_test.sv
// Self-checking bench for the terminal function assigner
`timescale 1ns/1ps
module io_signal_function_assigner_test;
  import io_assign_pkg::*;
  typedef struct packed {logic [7:0] code; logic [6:0] st; logic exp;} row_t;
  logic clock = 0, resetn = 0, three_wire_mode = 0, load_hold_enable = 0, shaft_held = 0;
  logic alarm_active = 0, motor_running = 0, warning_active = 0, internal_busy = 0;
  logic torque_at_limit = 0, shaft_forward = 0, shaft_step = 0, main_power_on = 0;
  logic [SPEED_W-1:0] feedback_speed = '0, command_speed = '0, speed_band = '0;
  logic [N_DIN-1:0] din_level;
  logic [CODE_W-1:0] din_code [N_DIN];
  logic [N_RIN-1:0] rin_level;
  logic [CODE_W-1:0] rin_code [N_RIN];
  logic [CODE_W-1:0] dout_code [N_DOUT];
  logic [N_DOUT-1:0] dout_invert;
  logic [CODE_W-1:0] rout_code [N_ROUT];
  logic [N_ROUT-1:0] rout_invert;
  logic [2:0] op_data_sel_q;
  logic instant_stop_q, direction_sel_q, shaft_free_q, external_fault_in_q;
  logic alarm_reset_echo_q, warning_clear_echo_q;
  logic [N_GENERAL-1:0] general_bits_q;
  logic [N_DOUT-1:0] dout_q;
  logic [N_ROUT-1:0] rout_q;
  logic [7:0] rises;
  logic prev;
  int errors = 0, samples_checked = 0;
  // Status order: power, forward, torque, busy, warning, running, alarm
  row_t rows [14] = '{
    '{8'h81, 7'h01, 1'b1}, '{8'h81, 7'h7e, 1'b0}, '{8'h82, 7'h01, 1'b0},
    '{8'h82, 7'h00, 1'b1}, '{8'h86, 7'h02, 1'b1}, '{8'h86, 7'h7d, 1'b0},
    '{8'h87, 7'h04, 1'b1}, '{8'h88, 7'h08, 1'b1}, '{8'h8c, 7'h10, 1'b1},
    '{8'h94, 7'h20, 1'b1}, '{8'h94, 7'h5f, 1'b0}, '{8'ha8, 7'h40, 1'b1},
    '{8'h00, 7'h7f, 1'b0}, '{8'h85, 7'h7f, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  always #5 clock = ~clock;
  host_io_model u_host_io_model (.clock(clock), .din_level(din_level), .din_code(din_code),
    .rin_level(rin_level), .rin_code(rin_code), .dout_code(dout_code),
    .dout_invert(dout_invert), .rout_code(rout_code), .rout_invert(rout_invert));
  io_signal_function_assigner u_io_signal_function_assigner (.clock(clock), .resetn(resetn),
    .three_wire_mode(three_wire_mode), .load_hold_enable(load_hold_enable),
    .shaft_held(shaft_held), .din_level(din_level), .din_code(din_code),
    .rin_level(rin_level), .rin_code(rin_code), .dout_code(dout_code),
    .dout_invert(dout_invert), .rout_code(rout_code), .rout_invert(rout_invert),
    .alarm_active(alarm_active), .motor_running(motor_running),
    .warning_active(warning_active), .internal_busy(internal_busy),
    .torque_at_limit(torque_at_limit), .feedback_speed(feedback_speed),
    .command_speed(command_speed), .speed_band(speed_band), .shaft_forward(shaft_forward),
    .shaft_step(shaft_step), .main_power_on(main_power_on), .op_data_sel_q(op_data_sel_q),
    .instant_stop_q(instant_stop_q), .direction_sel_q(direction_sel_q),
    .shaft_free_q(shaft_free_q), .general_bits_q(general_bits_q),
    .external_fault_in_q(external_fault_in_q), .alarm_reset_echo_q(alarm_reset_echo_q),
    .warning_clear_echo_q(warning_clear_echo_q), .dout_q(dout_q), .rout_q(rout_q));
  ////////////////////////////////////////////////////////////////////////////
  // Wait some edges, then let their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Single-bit comparison
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  // Multi-bit comparison
  task automatic check_field(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("errors %0d, samples checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(4);
    check_field({4'h0, general_bits_q}, 8'h0f, "reset general");
    check_bit(external_fault_in_q, 1'b1, "reset fault");
    check_field({2'h0, dout_q}, 8'h00, "reset dout");
    check_bit(|rout_q, 1'b0, "reset rout");
    check_bit(alarm_reset_echo_q | warning_clear_echo_q, 1'b0, "reset echoes");
    @(posedge clock) resetn <= 1'b1;
    // Status output codes on a direct and a remote terminal
    foreach (rows[i]) begin
      u_host_io_model.set_dout(0, rows[i].code, 1'b0);
      u_host_io_model.set_rout(0, rows[i].code, 1'b0);
      @(posedge clock);
      {main_power_on, shaft_forward, torque_at_limit, internal_busy, warning_active,
       motor_running, alarm_active} <= rows[i].st;
      tick(3);
      check_bit(dout_q[0], rows[i].exp, "dout status");
      check_bit(rout_q[0], rows[i].exp, "rout status");
    end
    // Operation data index from three select bits
    for (int n = 0; n < 8; n++) begin
      u_host_io_model.set_din(0, 8'h40, n[0]);
      u_host_io_model.set_din(1, 8'h41, n[1]);
      u_host_io_model.set_din(2, 8'h42, n[2]);
      tick(2);
      check_field({5'h0, op_data_sel_q}, n[7:0], "op select");
    end
    // Stop style in two-wire, direction in three-wire
    u_host_io_model.set_din(3, 8'h48, 1'b1);
    tick(2);
    check_bit(instant_stop_q, 1'b1, "instant stop");
    check_bit(direction_sel_q, 1'b0, "dir two-wire");
    @(posedge clock) three_wire_mode <= 1'b1;
    tick(2);
    check_bit(direction_sel_q, 1'b1, "dir forward");
    check_bit(instant_stop_q, 1'b0, "stop three-wire");
    u_host_io_model.set_din(3, 8'h48, 1'b0);
    tick(2);
    check_bit(direction_sel_q, 1'b0, "dir reverse");
    // Shaft hold release, its echo and its unassigned default
    u_host_io_model.set_din(4, 8'h4a, 1'b1);
    u_host_io_model.set_dout(0, 8'h4a, 1'b0);
    @(posedge clock) {load_hold_enable, shaft_held} <= 2'b11;
    tick(3);
    check_bit(shaft_free_q, 1'b1, "hold free");
    check_bit(dout_q[0], 1'b1, "hold echo");
    @(posedge clock) load_hold_enable <= 1'b0;
    tick(2);
    check_bit(shaft_free_q, 1'b0, "hold disabled");
    u_host_io_model.set_din(4, 8'h00, 1'b0);
    @(posedge clock) load_hold_enable <= 1'b1;
    tick(2);
    check_bit(shaft_free_q, 1'b1, "hold default");
    // General bits, one low at a time, echoed on a direct output
    for (int g = 0; g < 4; g++) begin
      u_host_io_model.set_din(5, 8'h50 + g[7:0], 1'b0);
      u_host_io_model.set_dout(1, 8'h50 + g[7:0], 1'b0);
      tick(3);
      check_field({4'h0, general_bits_q}, 8'h0f & ~(8'h01 << g), "general");
      check_bit(dout_q[1], 1'b0, "general echo");
    end
    u_host_io_model.set_din(5, 8'h00, 1'b0);
    // Alarm reset and warning clear functions echoed on their own outputs
    u_host_io_model.set_din(7, 8'h08, 1'b1);
    u_host_io_model.set_din(8, 8'h0e, 1'b1);
    tick(2);
    check_bit(alarm_reset_echo_q, 1'b1, "alarm reset echo");
    check_bit(warning_clear_echo_q, 1'b1, "warning clear echo");
    // External fault refused on remote, taken on direct
    u_host_io_model.set_rin(0, 8'h19, 1'b0);
    tick(2);
    check_bit(external_fault_in_q, 1'b1, "fault remote");
    u_host_io_model.set_din(6, 8'h19, 1'b0);
    tick(2);
    check_bit(external_fault_in_q, 1'b0, "fault direct");
    // Unused terminal ignores its invert
    u_host_io_model.set_dout(3, 8'h00, 1'b1);
    tick(2);
    check_bit(dout_q[3], 1'b0, "unused inverted");
    // Mapped flag follows its invert; main power is on here
    u_host_io_model.set_dout(3, 8'ha8, 1'b1);
    tick(2);
    check_bit(dout_q[3], 1'b0, "power inverted");
    // Speed band edges, inclusive
    @(posedge clock) {feedback_speed, command_speed, speed_band} <= {16'd100, 16'd110, 16'd10};
    u_host_io_model.set_dout(0, 8'h8d, 1'b0);
    tick(3);
    check_bit(dout_q[0], 1'b1, "speed in band");
    @(posedge clock) speed_band <= 16'd9;
    tick(3);
    check_bit(dout_q[0], 1'b0, "speed out band");
    // Sixty shaft steps give thirty pulses; remote pulse stays low
    u_host_io_model.set_dout(2, 8'h93, 1'b0);
    u_host_io_model.set_rout(0, 8'h93, 1'b1);
    tick(3);
    rises = 8'h00;
    prev = dout_q[2];
    for (int k = 0; k < 130; k++) begin
      @(posedge clock) shaft_step <= (k < 120) && (k % 2 == 0);
      #1;
      if (dout_q[2] === 1'b1 && prev === 1'b0) rises++;
      prev = dout_q[2];
      if (k % 16 == 0) check_bit(rout_q[0], 1'b0, "remote pulse");
    end
    check_field(rises, 8'd30, "pulse count");
    // Mid-run reset returns outputs to their reset levels
    @(posedge clock) resetn <= 1'b0;
    tick(2);
    check_field({2'h0, dout_q}, 8'h00, "rerun dout");
    check_field({5'h0, op_data_sel_q}, 8'h00, "rerun select");
    check_bit(shaft_free_q, 1'b0, "rerun free");
    summarize();
  end
endmodule
